// ===== pkg/mbdkc_pkg.sv
// constants and types of the multi-bin dft knock conditioner
// assumes one 50 MHz clock and a synchronous active-high reset
//
// How it works
// R01: each sample adds x*cos, x*sin per bin
// R02: one step per sample, stall without sample
// R03: two multiplies, two adds per bin
// R04: only the current sample is held
// R05: source delivers samples at 40 kHz or faster
// R06: one sine table, cosine and sine pointers
// R07: table holds N entries, one period
// R08: bin k steps table by k
// R09: block length any integer, not power-of-two
// R10: block end: magnitude is re^2 plus im^2
// R11: low speed uses several equal-length blocks
// R12: keep bins of block with largest total
// R13: five bins, own accumulators and peaks
// R14: after last block, present peak magnitudes
// R15: controller runs window 10-70 degrees ATDC
// R16: clear accumulators per block, maximum per window
// R17: one-cycle valid pulse with new peaks
package mbdkc_pkg;
  localparam int NUM_BINS = 5;
  localparam int SAMPLE_W = 16;
  localparam int COEF_W = 16;
  localparam int BLEN_W = 10;
  localparam int TBL_DEPTH = 1 << BLEN_W;
  localparam int BLKS_W = 8;
  localparam int ACC_W = SAMPLE_W + COEF_W + BLEN_W;
  localparam int MAG_W = 2 * ACC_W;
  localparam int SUM_W = MAG_W + 3;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] LAST_BIN = 3'h4;
  localparam logic [BLEN_W-1:0] PTR_RESET = 10'h000;
  // per-sample budget; one sample costs NUM_BINS + 1 cycles, far inside it
  localparam int CLK_PERIOD_NS = 20;
  localparam int SAMPLE_RATE_MIN_HZ = 40000;
  localparam int SAMPLE_BUDGET_NS = 1000000000 / SAMPLE_RATE_MIN_HZ;
  localparam int BUDGET_CYCLES = SAMPLE_BUDGET_NS / CLK_PERIOD_NS;
  typedef logic [BLEN_W-1:0] mbdkc_idx_t;
  typedef logic [NUM_BINS-1:0][BLEN_W-1:0] mbdkc_kvec_t;
  typedef logic [NUM_BINS-1:0][MAG_W-1:0] mbdkc_mvec_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_ACCUM = 3'h3,
    ST_MAG = 3'h2,
    ST_CMP = 3'h6,
    ST_PRESENT = 3'h7
  } mbdkc_state_t;
endpackage

// ===== pkg/mbdkc_stream_if.sv
// sample stream between the input fifo and the dft engine
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface mbdkc_stream_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== logic/mbdkc_fifo.sv
// small sample fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module mbdkc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  mbdkc_stream_if.src out_side
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] step_ptr(input logic [AW-1:0] p);
    step_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_side.valid = (count_reg != '0);
  assign out_side.data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_side.valid && out_side.ready;

  always_comb
  begin
    wr_ptr_next = push ? step_ptr(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = pop ? step_ptr(rd_ptr_reg) : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 1'b1;
    else if (pop && !push)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // storage needs no reset; count gates every read
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end
endmodule
`default_nettype wire

// ===== logic/mbdkc_conditioner.sv
// five-bin single-point dft conditioner for a knock sensor stream
// assumes samples, table loads and window starts on clk; detection stage
// samples peak_mag when peak_valid pulses
`timescale 1ns/1ps
`default_nettype none
module mbdkc_conditioner (
  input wire logic clk,
  input wire logic reset,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [mbdkc_pkg::SAMPLE_W-1:0] sample_data,
  input wire logic tbl_wr_en,
  input wire logic [mbdkc_pkg::BLEN_W-1:0] tbl_wr_addr,
  input wire logic [mbdkc_pkg::COEF_W-1:0] tbl_wr_data,
  input wire logic window_start,
  input wire logic [mbdkc_pkg::BLEN_W-1:0] block_len,
  input wire logic [mbdkc_pkg::BLKS_W-1:0] blocks_per_window,
  input wire mbdkc_pkg::mbdkc_kvec_t bin_k,
  output mbdkc_pkg::mbdkc_mvec_t peak_mag,
  output logic peak_valid,
  output logic busy
);
  import mbdkc_pkg::*;

  // ****************************************
  // sample fifo
  // ****************************************
  mbdkc_stream_if #(.WIDTH(SAMPLE_W)) smp_if ();

  mbdkc_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_side(smp_if)
  );

  // ****************************************
  // shared sine table
  // ****************************************
  logic signed [COEF_W-1:0] sine_tbl [TBL_DEPTH];

  // one period of the lowest sine, N entries, loaded before a window [R07]
  always_ff @(posedge clk)
  begin
    if (tbl_wr_en)
      sine_tbl[tbl_wr_addr] <= tbl_wr_data;
  end

  // ****************************************
  // functions
  // ****************************************
  // pointer step modulo any block length, not just powers of two
  function automatic mbdkc_idx_t wrap_add(
    input mbdkc_idx_t p,
    input mbdkc_idx_t step,
    input mbdkc_idx_t n
  );
    logic [BLEN_W:0] s;
    s = {1'b0, p} + {1'b0, step};
    if (s >= {1'b0, n})
      s = s - {1'b0, n};
    wrap_add = s[BLEN_W-1:0];
  endfunction

  function automatic logic signed [ACC_W-1:0] mac(
    input logic signed [ACC_W-1:0] acc,
    input logic signed [SAMPLE_W-1:0] x,
    input logic signed [COEF_W-1:0] c
  );
    logic signed [SAMPLE_W+COEF_W-1:0] prod;
    prod = x * c;
    mac = acc + ACC_W'(prod);
  endfunction

  function automatic logic [MAG_W-1:0] square(input logic signed [ACC_W-1:0] a);
    logic signed [MAG_W-1:0] wide;
    logic signed [MAG_W-1:0] prod;
    wide = MAG_W'(a);
    prod = wide * wide;
    square = $unsigned(prod);
  endfunction

  // ****************************************
  // control state
  // ****************************************
  mbdkc_state_t state_reg;
  mbdkc_state_t state_next;
  mbdkc_idx_t len_reg;
  mbdkc_idx_t len_next;
  logic [BLKS_W-1:0] blocks_reg;
  logic [BLKS_W-1:0] blocks_next;
  mbdkc_kvec_t k_reg;
  mbdkc_kvec_t k_next;
  logic signed [SAMPLE_W-1:0] x_reg;
  logic signed [SAMPLE_W-1:0] x_next;
  logic [2:0] bin_reg;
  logic [2:0] bin_next;
  mbdkc_idx_t smp_cnt_reg;
  mbdkc_idx_t smp_cnt_next;
  logic [BLKS_W-1:0] blk_cnt_reg;
  logic [BLKS_W-1:0] blk_cnt_next;

  // samples outside a window are drained and dropped in idle; any still queued at window_start feed the new window
  assign smp_if.ready = ((state_reg == ST_WAIT) || (state_reg == ST_IDLE)) && !window_start;
  assign busy = (state_reg != ST_IDLE);

  always_comb
  begin
    state_next = state_reg;
    len_next = len_reg;
    blocks_next = blocks_reg;
    k_next = k_reg;
    x_next = x_reg;
    bin_next = bin_reg;
    smp_cnt_next = smp_cnt_reg;
    blk_cnt_next = blk_cnt_reg;
    if (window_start)
    begin
      state_next = ST_WAIT;
      len_next = block_len; // [R09]
      blocks_next = blocks_per_window;
      k_next = bin_k;
      smp_cnt_next = '0;
      blk_cnt_next = '0;
      bin_next = '0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          state_next = ST_IDLE;
        end
        ST_WAIT:
        begin
          // no sample: stay here, nothing accumulates [R02]
          if (smp_if.valid)
          begin
            x_next = smp_if.data; // [R04]
            bin_next = '0;
            state_next = ST_ACCUM;
          end
        end
        ST_ACCUM:
        begin
          if (bin_reg == LAST_BIN)
          begin
            bin_next = '0;
            if (smp_cnt_reg == len_reg - 1'b1)
            begin
              smp_cnt_next = '0;
              state_next = ST_MAG;
            end
            else
            begin
              smp_cnt_next = smp_cnt_reg + 1'b1;
              state_next = ST_WAIT; // [R02]
            end
          end
          else
            bin_next = bin_reg + 1'b1;
        end
        ST_MAG:
        begin
          if (bin_reg == LAST_BIN)
          begin
            bin_next = '0;
            state_next = ST_CMP;
          end
          else
            bin_next = bin_reg + 1'b1;
        end
        ST_CMP:
        begin
          // same block length repeated to span a long window [R11]
          if (blk_cnt_reg == blocks_reg - 1'b1)
            state_next = ST_PRESENT;
          else
          begin
            blk_cnt_next = blk_cnt_reg + 1'b1;
            state_next = ST_WAIT;
          end
        end
        ST_PRESENT:
        begin
          state_next = ST_IDLE;
        end
        default:
        begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      len_reg <= '0;
      blocks_reg <= '0;
      k_reg <= '0;
      x_reg <= '0;
      bin_reg <= '0;
      smp_cnt_reg <= '0;
      blk_cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      len_reg <= len_next;
      blocks_reg <= blocks_next;
      k_reg <= k_next;
      x_reg <= x_next;
      bin_reg <= bin_next;
      smp_cnt_reg <= smp_cnt_next;
      blk_cnt_reg <= blk_cnt_next;
    end
  end

  // ****************************************
  // datapath state
  // ****************************************
  logic signed [ACC_W-1:0] acc_re_reg [NUM_BINS];
  logic signed [ACC_W-1:0] acc_re_next [NUM_BINS];
  logic signed [ACC_W-1:0] acc_im_reg [NUM_BINS];
  logic signed [ACC_W-1:0] acc_im_next [NUM_BINS];
  mbdkc_idx_t ptr_cos_reg [NUM_BINS];
  mbdkc_idx_t ptr_cos_next [NUM_BINS];
  mbdkc_idx_t ptr_sin_reg [NUM_BINS];
  mbdkc_idx_t ptr_sin_next [NUM_BINS];
  mbdkc_mvec_t mag_reg;
  mbdkc_mvec_t mag_next;
  mbdkc_mvec_t peak_reg;
  mbdkc_mvec_t peak_next;
  mbdkc_mvec_t peak_out_reg;
  mbdkc_mvec_t peak_out_next;
  logic [SUM_W-1:0] sum_reg;
  logic [SUM_W-1:0] sum_next;
  logic [SUM_W-1:0] max_reg;
  logic [SUM_W-1:0] max_next;
  logic peak_valid_reg;
  logic peak_valid_next;
  mbdkc_idx_t cos_start;
  logic [MAG_W-1:0] bin_mag;

  // cosine is the sine table a quarter period on; exact only when N is a
  // multiple of four, otherwise the cosine phase is off by under one entry
  assign cos_start = (window_start ? block_len : len_reg) >> 2;
  assign bin_mag = square(acc_re_reg[bin_reg]) + square(acc_im_reg[bin_reg]); // [R10]
  assign peak_mag = peak_out_reg;
  assign peak_valid = peak_valid_reg;

  always_comb
  begin
    acc_re_next = acc_re_reg;
    acc_im_next = acc_im_reg;
    ptr_cos_next = ptr_cos_reg;
    ptr_sin_next = ptr_sin_reg;
    mag_next = mag_reg;
    peak_next = peak_reg;
    peak_out_next = peak_out_reg;
    sum_next = sum_reg;
    max_next = max_reg;
    peak_valid_next = 1'b0;
    // fresh accumulators and phases at every block start [R16]
    if (window_start || (state_reg == ST_CMP))
    begin
      for (int b = 0; b < NUM_BINS; b++)
      begin
        acc_re_next[b] = '0;
        acc_im_next[b] = '0;
        ptr_cos_next[b] = cos_start;
        ptr_sin_next[b] = PTR_RESET;
      end
      sum_next = '0;
    end
    if (window_start)
    begin
      max_next = '0; // [R16]
      peak_next = '0;
    end
    else
    begin
      unique case (state_reg)
        ST_ACCUM:
        begin
          // one bin per cycle: two products, two sums [R01] [R03] [R13]
          acc_re_next[bin_reg] = mac(acc_re_reg[bin_reg], x_reg,
            sine_tbl[ptr_cos_reg[bin_reg]]); // [R06]
          acc_im_next[bin_reg] = mac(acc_im_reg[bin_reg], x_reg,
            sine_tbl[ptr_sin_reg[bin_reg]]); // [R06]
          // stepping by k selects bin frequency k * fs / N [R08]
          ptr_cos_next[bin_reg] = wrap_add(ptr_cos_reg[bin_reg], k_reg[bin_reg], len_reg);
          ptr_sin_next[bin_reg] = wrap_add(ptr_sin_reg[bin_reg], k_reg[bin_reg], len_reg);
        end
        ST_MAG:
        begin
          mag_next[bin_reg] = bin_mag; // [R10]
          sum_next = sum_reg + SUM_W'(bin_mag); // [R12]
        end
        ST_CMP:
        begin
          // strictly greater: ties keep the earlier block
          if (sum_reg > max_reg)
          begin
            max_next = sum_reg; // [R12]
            peak_next = mag_reg; // [R12]
          end
        end
        ST_PRESENT:
        begin
          peak_out_next = peak_reg; // [R14]
          peak_valid_next = 1'b1; // [R17]
        end
        default:
        begin
          peak_valid_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int b = 0; b < NUM_BINS; b++)
      begin
        acc_re_reg[b] <= '0;
        acc_im_reg[b] <= '0;
        ptr_cos_reg[b] <= PTR_RESET;
        ptr_sin_reg[b] <= PTR_RESET;
      end
      mag_reg <= '0;
      peak_reg <= '0;
      peak_out_reg <= '0;
      sum_reg <= '0;
      max_reg <= '0;
      peak_valid_reg <= 1'b0;
    end
    else
    begin
      acc_re_reg <= acc_re_next;
      acc_im_reg <= acc_im_next;
      ptr_cos_reg <= ptr_cos_next;
      ptr_sin_reg <= ptr_sin_next;
      mag_reg <= mag_next;
      peak_reg <= peak_next;
      peak_out_reg <= peak_out_next;
      sum_reg <= sum_next;
      max_reg <= max_next;
      peak_valid_reg <= peak_valid_next;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/mbdkc_conditioner_properties.sv
// port checker for the dft knock conditioner, bound to its top module
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module mbdkc_conditioner_properties
  import mbdkc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic window_start,
  input wire logic sample_ready,
  input wire mbdkc_pkg::mbdkc_mvec_t peak_mag,
  input wire logic peak_valid,
  input wire logic busy
);
  // ****************************************
  // window age, saturating so it never wraps
  // ****************************************
  logic [15:0] age_reg;
  logic [15:0] age_next;
  always_comb
  begin
    age_next = age_reg;
    if (window_start)
      age_next = 16'h0000;
    else if (age_reg != 16'hFFFF)
      age_next = age_reg + 16'h0001;
  end
  always_ff @(posedge clk)
    age_reg <= reset ? 16'hFFFF : age_next;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_reset_vals: assert property (
    $fell(reset) |-> !busy && !peak_valid && peak_mag == '0 && sample_ready)
    else $error("outputs not at reset values");
  chk_min_latency: assert property (
    window_start |=> (busy && !peak_valid)[*8])
    else $error("window finished too early");
  chk_idle_hold: assert property (
    !busy && !window_start |=> !busy && !peak_valid)
    else $error("engine left idle without a window start");
  chk_pulse_once: assert property (
    peak_valid |=> !peak_valid)
    else $error("peak_valid longer than one cycle");
  chk_done_idle: assert property (
    peak_valid |-> !busy && $past(busy))
    else $error("peak_valid not at end of a busy window");
  chk_fell_valid: assert property (
    $fell(busy) && !$past(reset) |-> peak_valid)
    else $error("window ended without peak_valid");
  chk_peak_hold: assert property (
    !peak_valid && !$past(reset) |-> $stable(peak_mag))
    else $error("peak_mag changed without peak_valid");
  chk_window_age: assert property (
    peak_valid |-> age_reg >= 16'h000D)
    else $error("result sooner than one sample plus block end");
endmodule
bind mbdkc_conditioner mbdkc_conditioner_properties mbdkc_conditioner_properties_i (
  .clk(clk),
  .reset(reset),
  .window_start(window_start),
  .sample_ready(sample_ready),
  .peak_mag(peak_mag),
  .peak_valid(peak_valid),
  .busy(busy)
);
`default_nettype wire

// ===== testbench/mbdkc_sample_src.sv
// knock sensor sample source model, fed through its queue q
// assumes the bench sets q and gap; drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module mbdkc_sample_src
  import mbdkc_pkg::*;
(
  input wire logic clk,
  input wire logic sample_ready,
  output logic sample_valid,
  output logic [SAMPLE_W-1:0] sample_data
);
  logic signed [SAMPLE_W-1:0] q [$];
  int gap = 0;
  // idle data toggles so a stale word never passes for a sample
  initial
  begin
    sample_valid = 1'b0;
    sample_data = '0;
    forever
    begin
      @(negedge clk);
      if (q.size() == 0)
      begin
        sample_valid = 1'b0;
        sample_data = ~sample_data;
      end
      else
      begin
        sample_valid = 1'b1;
        sample_data = q[0];
        // bounded wait; a lost sample shows up as a bench timeout
        @(posedge clk);
        for (int w = 0; w < 1000 && sample_ready !== 1'b1; w++)
          @(posedge clk);
        void'(q.pop_front());
        repeat (gap)
        begin
          @(negedge clk);
          sample_valid = 1'b0;
          sample_data = ~sample_data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/mbdkc_conditioner_tb.sv
// self-checking bench for the dft knock conditioner
// assumes block length 5, table loaded once, bins k = 0..4
`timescale 1ns/1ps
`default_nettype none
module mbdkc_conditioner_tb;
  import mbdkc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sample_valid, sample_ready, tbl_wr_en, window_start, peak_valid, busy;
  logic [SAMPLE_W-1:0] sample_data;
  logic [BLEN_W-1:0] tbl_wr_addr, block_len;
  logic [COEF_W-1:0] tbl_wr_data;
  logic [BLKS_W-1:0] blocks_per_window;
  mbdkc_kvec_t bin_k;
  mbdkc_mvec_t peak_mag, best, blk;
  logic signed [COEF_W-1:0] tbl [0:4] = '{16'h0003, 16'h0007, 16'hFFFE, 16'h0005, 16'hFFFA};
  logic signed [SAMPLE_W-1:0] xs [$];
  logic signed [ACC_W-1:0] re [0:4];
  logic signed [ACC_W-1:0] im [0:4];
  logic [SUM_W-1:0] tot, mx;
  logic saw_full = 1'b0;
  int failures = 0;
  int num_checks = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (sample_valid && !sample_ready) saw_full <= 1'b1;
  mbdkc_conditioner mbdkc_conditioner_i (.clk(clk), .reset(reset),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
    .tbl_wr_en(tbl_wr_en), .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data),
    .window_start(window_start), .block_len(block_len),
    .blocks_per_window(blocks_per_window), .bin_k(bin_k), .peak_mag(peak_mag),
    .peak_valid(peak_valid), .busy(busy));
  mbdkc_sample_src mbdkc_sample_src_i (.clk(clk), .sample_ready(sample_ready),
    .sample_valid(sample_valid), .sample_data(sample_data));
  // ****************************************
  // compare, closing and window tasks
  // ****************************************
  task chk_mag(input string what, input logic [MAG_W-1:0] exp, input logic [MAG_W-1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // expectation keeps the block with the strictly largest total
  task run_win(input int nblk, input int gap, input string name);
    int i;
    mx = '0;
    best = '0;
    for (int b = 0; b < nblk; b++)
    begin
      tot = '0;
      for (int k = 0; k < NUM_BINS; k++)
      begin
        re[k] = '0;
        im[k] = '0;
        for (int n = 0; n < 5; n++)
        begin
          re[k] = re[k] + xs[b*5+n] * tbl[(1 + k*n) % 5];
          im[k] = im[k] + xs[b*5+n] * tbl[(k*n) % 5];
        end
        blk[k] = re[k] * re[k] + im[k] * im[k];
        tot = tot + blk[k];
      end
      if (tot > mx)
      begin
        mx = tot;
        best = blk;
      end
    end
    blocks_per_window = nblk[BLKS_W-1:0];
    @(negedge clk);
    window_start = 1'b1;
    mbdkc_sample_src_i.gap = gap;
    mbdkc_sample_src_i.q = xs;
    @(negedge clk);
    window_start = 1'b0;
    i = 0;
    while (peak_valid !== 1'b1 && i < 4000)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 4000)
    begin
      failures++;
      $display("CHECK FAILED peak_valid expected 1 seen timeout");
      end_sim;
    end
    for (int k = 0; k < NUM_BINS; k++)
      chk_mag($sformatf("%s bin %0d", name, k), best[k], peak_mag[k]);
    chk_bit($sformatf("%s busy", name), 1'b0, busy);
    $display("%s finished", name);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task test_single;
    xs = '{16'h0064, 16'hFF38, 16'h012C, 16'hFE70, 16'h01F4};
    run_win(1, 20, "single_slow_source");
  endtask
  task test_multi;
    int scale [0:2];
    scale = '{2, 40, 9};
    xs.delete();
    for (int b = 0; b < 3; b++)
      for (int n = 0; n < 5; n++)
        xs.push_back(16'((n % 2 == 1) ? -(n + 1) * scale[b] : (n + 1) * scale[b]));
    run_win(3, 0, "three_blocks");
    chk_bit("sample_ready refused when full", 1'b1, saw_full);
  endtask
  // restart lands while the last aborted sample is still accumulating
  task test_abort_zero;
    @(negedge clk);
    window_start = 1'b1;
    mbdkc_sample_src_i.gap = 20;
    mbdkc_sample_src_i.q = '{16'h7FFF, 16'h8001, 16'h7FFF};
    @(negedge clk);
    window_start = 1'b0;
    for (int i = 0; i < 200 && mbdkc_sample_src_i.q.size() != 0; i++)
      @(negedge clk);
    if (mbdkc_sample_src_i.q.size() != 0)
    begin
      failures++;
      $display("CHECK FAILED abort samples left expected 0 seen %0d",
        mbdkc_sample_src_i.q.size());
      end_sim;
    end
    repeat (3) @(negedge clk);
    xs = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    run_win(1, 0, "abort_then_zero");
  endtask
  initial
  begin
    tbl_wr_en = 1'b0;
    tbl_wr_addr = '0;
    tbl_wr_data = '0;
    window_start = 1'b0;
    block_len = 10'h005;
    blocks_per_window = 8'h01;
    for (int k = 0; k < NUM_BINS; k++)
      bin_k[k] = k[BLEN_W-1:0];
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      tbl_wr_en = 1'b1;
      tbl_wr_addr = i[BLEN_W-1:0];
      tbl_wr_data = tbl[i];
      @(negedge clk);
    end
    tbl_wr_en = 1'b0;
    test_single;
    test_multi;
    test_abort_zero;
    end_sim;
  end
endmodule
`default_nettype wire
